// ==== inc/hzs_pkg.sv ====
package hzs_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned DEB_SHORT_MS = 115;
    localparam int unsigned DEB_LONG_MS = 300;
    // least times round up; both divide evenly at this rate
    localparam int unsigned DEB_SHORT_CYCLES =
        (CLK_HZ / 1000) * DEB_SHORT_MS;
    localparam int unsigned DEB_LONG_CYCLES =
        (CLK_HZ / 1000) * DEB_LONG_MS;
    localparam int unsigned DEB_CNT_W = 23;

    // ----------------------------------------------------------------
    // widths and encodings
    // ----------------------------------------------------------------
    localparam int unsigned RESULT_W = 8;
    localparam logic [1:0] CUR_100UA = 2'h0;
    localparam logic [1:0] CUR_1MA1 = 2'h1;
    localparam logic [1:0] CUR_5MA5 = 2'h2;
    localparam logic [1:0] START_SEL_AUTO = 2'h0;
    localparam logic [1:0] START_SEL_MAN_A = 2'h1;
    localparam logic [1:0] START_SEL_MAN_B = 2'h2;
    localparam logic [1:0] SEL_RESET = CUR_100UA;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // gray codes along idle -> mux -> start -> wait -> eval
    typedef enum logic [2:0] {
        HZS_IDLE  = 3'h0,
        HZS_MUX   = 3'h1,
        HZS_START = 3'h3,
        HZS_WAIT  = 3'h2,
        HZS_EVAL  = 3'h6
    } hzs_state_e;

endpackage

// ==== src/hzs_jack_debounce.sv ====
`timescale 1ns/100ps
`default_nettype none

module hzs_jack_debounce
    import hzs_pkg::*;
#(
    parameter int unsigned SHORT_CYC = DEB_SHORT_CYCLES,
    parameter int unsigned LONG_CYC = DEB_LONG_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // jack pin and setting
    input wire logic jack_sense_input,
    input wire logic long_select,
    // debounced state and events
    output logic present_low,
    output logic insert_pulse,
    output logic remove_pulse
);

    logic sync1_reg;
    logic sync2_reg;
    logic [DEB_CNT_W-1:0] cnt_reg, cnt_next;
    logic present_reg, present_next;
    logic ins_reg, ins_next;
    logic rem_reg, rem_next;
    logic [DEB_CNT_W-1:0] limit;

    assign limit = long_select ? DEB_CNT_W'(LONG_CYC - 1)
                               : DEB_CNT_W'(SHORT_CYC - 1);

    // ----------------------------------------------------------------
    // comparator level, falling edge debounced, rising edge immediate
    // ----------------------------------------------------------------
    always_comb
    begin
        cnt_next = cnt_reg;
        present_next = present_reg;
        ins_next = 1'b0;
        rem_next = 1'b0;
        if (sync2_reg)
        begin
            cnt_next = '0;
            present_next = 1'b0;
            rem_next = present_reg;
        end
        else if (!present_reg)
        begin
            if (cnt_reg >= limit)
            begin
                present_next = 1'b1;
                ins_next = 1'b1;
                cnt_next = '0;
            end
            else
            begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            cnt_reg <= '0;
            present_reg <= 1'b0;
            ins_reg <= 1'b0;
            rem_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= jack_sense_input;
            sync2_reg <= sync1_reg;
            cnt_reg <= cnt_next;
            present_reg <= present_next;
            ins_reg <= ins_next;
            rem_reg <= rem_next;
        end
    end

    assign present_low = present_reg;
    assign insert_pulse = ins_reg;
    assign remove_pulse = rem_reg;

endmodule

`default_nettype wire

// ==== src/hzs_sequencer.sv ====
// Function
// - ready is flagged once start-up ends and only then do measurements run.
// - auto mode starts a run when presence goes low after debounce.
// - a two-bit field picks auto or manual start; manual needs presence.
// - an auto run first closes the mic and ground switches as CTIA.
// - with open check on, the run begins at 100 uA for a high-Z reading.
// - high-Z under threshold, or no open check, leads to a 1.1 mA run.
// - a 1.1 mA result still too low is repeated at 5.5 mA.
// - start-select 01 or 10 measures only on a rising manual trigger.
// - manual runs use the current named by the current-select field.
// - an auto run loads the current-select field with its last current.
// - the interrupt pin is active low open drain and never drives high.
// - the jack sense input is watched always for insertion and removal.
// - each result is an 8-bit converter reading used for all comparisons.
// - insertion debounce is 115 ms, or 300 ms with the long select set.
`timescale 1ns/100ps
`default_nettype none

module hzs_sequencer
    import hzs_pkg::*;
#(
    parameter int unsigned DEB_SHORT_CYC = DEB_SHORT_CYCLES,
    parameter int unsigned DEB_LONG_CYC = DEB_LONG_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // start-up and jack pin
    input wire logic startup_done,
    input wire logic jack_sense_input,
    // configuration
    input wire logic insert_debounce_select,
    input wire logic open_check_enable,
    input wire logic [1:0] measure_start_select,
    input wire logic manual_measure_trigger,
    input wire logic [7:0] high_z_threshold,
    input wire logic [7:0] low_z_threshold,
    input wire logic sense_current_select_wr,
    input wire logic [1:0] sense_current_select_wdata,
    input wire logic irq_pending,
    // impedance converter
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    // analog controls
    output logic sense_current_on,
    output logic [1:0] sense_current,
    output logic mux_ctia_closed,
    // status
    output logic device_ready,
    output logic jack_present_low,
    output logic insert_event,
    output logic remove_event,
    output logic busy,
    output logic result_valid,
    output logic [RESULT_W-1:0] result,
    output logic [1:0] sense_current_select,
    // open-drain interrupt pin
    output logic int_n_out,
    output logic int_n_oe
);

    hzs_state_e state_reg, state_next;
    logic ready_reg, ready_next;
    logic auto_reg, auto_next;
    logic trig_d_reg;
    logic pres_d_reg;
    logic start_reg, start_next;
    logic cur_on_reg, cur_on_next;
    logic [1:0] cur_reg, cur_next;
    logic mux_reg, mux_next;
    logic [RESULT_W-1:0] sample_reg, sample_next;
    logic [RESULT_W-1:0] result_reg, result_next;
    logic valid_reg, valid_next;
    logic [1:0] sel_reg, sel_next;
    logic busy_reg, busy_next;
    logic oe_reg;
    logic pres_low;
    logic manual_mode;
    logic auto_go;
    logic manual_go;

    // ----------------------------------------------------------------
    // jack presence
    // ----------------------------------------------------------------
    hzs_jack_debounce #(
        .SHORT_CYC(DEB_SHORT_CYC),
        .LONG_CYC(DEB_LONG_CYC)
    ) u_debounce (
        .clock(clock),
        .reset(reset),
        .jack_sense_input(jack_sense_input),
        .long_select(insert_debounce_select),
        .present_low(pres_low),
        .insert_pulse(insert_event),
        .remove_pulse(remove_event)
    );

    // ----------------------------------------------------------------
    // start decisions
    // ----------------------------------------------------------------
    assign manual_mode = (measure_start_select == START_SEL_MAN_A) ||
                         (measure_start_select == START_SEL_MAN_B);
    // presence rising edge, qualified by readiness
    assign auto_go = ready_reg && !manual_mode &&
                     pres_low && !pres_d_reg;
    // triggers while absent or busy are dropped, not queued
    assign manual_go = ready_reg && manual_mode && pres_low &&
                       manual_measure_trigger && !trig_d_reg &&
                       (state_reg == HZS_IDLE);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        ready_next = ready_reg | startup_done;
        auto_next = auto_reg;
        start_next = 1'b0;
        cur_on_next = cur_on_reg;
        cur_next = cur_reg;
        mux_next = mux_reg;
        sample_next = sample_reg;
        result_next = result_reg;
        valid_next = 1'b0;
        sel_next = sel_reg;
        if (sense_current_select_wr)
        begin
            sel_next = sense_current_select_wdata;
        end
        unique case (state_reg)
            HZS_IDLE:
            begin
                if (auto_go)
                begin
                    auto_next = 1'b1;
                    cur_next = open_check_enable ? CUR_100UA
                                                 : CUR_1MA1;
                    state_next = HZS_MUX;
                end
                else if (manual_go)
                begin
                    auto_next = 1'b0;
                    cur_next = sel_reg;
                    state_next = HZS_START;
                end
            end
            HZS_MUX:
            begin
                // switches settle a cycle before any current flows
                mux_next = 1'b1;
                state_next = HZS_START;
            end
            HZS_START:
            begin
                cur_on_next = 1'b1;
                start_next = 1'b1;
                state_next = HZS_WAIT;
            end
            HZS_WAIT:
            begin
                if (conv_done)
                begin
                    sample_next = conv_result;
                    state_next = HZS_EVAL;
                end
            end
            HZS_EVAL:
            begin
                state_next = HZS_IDLE;
                cur_on_next = 1'b0;
                if (auto_reg && cur_reg == CUR_100UA &&
                    sample_reg < high_z_threshold)
                begin
                    cur_next = CUR_1MA1;
                    state_next = HZS_START;
                end
                else if (auto_reg && cur_reg == CUR_1MA1 &&
                         sample_reg < low_z_threshold)
                begin
                    cur_next = CUR_5MA5;
                    state_next = HZS_START;
                end
                else
                begin
                    result_next = sample_reg;
                    valid_next = 1'b1;
                    if (auto_reg)
                    begin
                        // hardware load wins over a host write this cycle
                        sel_next = cur_reg;
                    end
                end
            end
            default:
            begin
                state_next = HZS_IDLE;
            end
        endcase
        // removal aborts; the previous result stays
        if (!pres_low && state_reg != HZS_IDLE)
        begin
            state_next = HZS_IDLE;
            cur_on_next = 1'b0;
            start_next = 1'b0;
            valid_next = 1'b0;
            result_next = result_reg;
        end
        if (!pres_low)
        begin
            mux_next = 1'b0;
        end
        busy_next = (state_next != HZS_IDLE);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_reg <= HZS_IDLE;
            ready_reg <= 1'b0;
            auto_reg <= 1'b0;
            trig_d_reg <= 1'b0;
            pres_d_reg <= 1'b0;
            start_reg <= 1'b0;
            cur_on_reg <= 1'b0;
            cur_reg <= CUR_100UA;
            mux_reg <= 1'b0;
            sample_reg <= RESULT_RESET;
            result_reg <= RESULT_RESET;
            valid_reg <= 1'b0;
            sel_reg <= SEL_RESET;
            oe_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            auto_reg <= auto_next;
            trig_d_reg <= manual_measure_trigger;
            pres_d_reg <= pres_low;
            start_reg <= start_next;
            cur_on_reg <= cur_on_next;
            cur_reg <= cur_next;
            mux_reg <= mux_next;
            sample_reg <= sample_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            sel_reg <= sel_next;
            oe_reg <= irq_pending;
            busy_reg <= busy_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign conv_start = start_reg;
    assign sense_current_on = cur_on_reg;
    assign sense_current = cur_reg;
    assign mux_ctia_closed = mux_reg;
    assign device_ready = ready_reg;
    assign jack_present_low = pres_low;
    assign busy = busy_reg;
    assign result_valid = valid_reg;
    assign result = result_reg;
    assign sense_current_select = sel_reg;
    // pin only ever pulls low
    assign int_n_out = 1'b0;
    assign int_n_oe = oe_reg;

endmodule

`default_nettype wire

// ==== verif/hzs_conv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module hzs_conv_model
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // converter handshake
    input wire logic conv_start,
    input wire logic [1:0] sense_current,
    output logic conv_done,
    output logic [7:0] conv_result = 8'h5a,
    // readings per current and answer delay
    input wire logic [23:0] levels,
    input wire logic [3:0] delay
);
    int cnt;
    logic [1:0] cur;
    always @(posedge clock)
    begin
        conv_done <= 1'b0;
        // idle bus toggles so a stale reading never looks valid
        conv_result <= ~conv_result;
        if (reset)
            cnt <= 0;
        else if (conv_start)
        begin
            cnt <= delay + 1;
            cur <= sense_current;
        end
        else if (cnt == 1)
        begin
            conv_done <= 1'b1;
            conv_result <= levels[cur*8 +: 8];
            cnt <= 0;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// ==== verif/hzs_sequencer_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module hzs_sequencer_chk
    import hzs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // inputs
    input wire logic startup_done,
    input wire logic manual_measure_trigger,
    input wire logic [1:0] measure_start_select,
    input wire logic open_check_enable,
    input wire logic [7:0] low_z_threshold,
    input wire logic irq_pending,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    // outputs
    input wire logic conv_start,
    input wire logic sense_current_on,
    input wire logic [1:0] sense_current,
    input wire logic [1:0] sense_current_select,
    input wire logic mux_ctia_closed,
    input wire logic device_ready,
    input wire logic jack_present_low,
    input wire logic insert_event,
    input wire logic remove_event,
    input wire logic busy,
    input wire logic result_valid,
    input wire logic [RESULT_W-1:0] result,
    input wire logic int_n_out,
    input wire logic int_n_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // 11 counts as automatic as well
    wire auto_go = insert_event && device_ready && !busy &&
        (measure_start_select[0] == measure_start_select[1]);
    wire man_ok = (measure_start_select[0] != measure_start_select[1]) &&
        jack_present_low && device_ready && !busy;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_ready_follows: assert property (
        $rose(startup_done) |-> ##[1:2] device_ready)
        else $error("ready flag late");
    chk_start_gated: assert property (
        conv_start |-> device_ready && $past(jack_present_low))
        else $error("conversion without ready jack");
    chk_auto_order: assert property (
        auto_go |-> ##2 (mux_ctia_closed && !sense_current_on) ##1
        (conv_start && sense_current ==
        (open_check_enable ? CUR_100UA : CUR_1MA1)))
        else $error("auto run order wrong");
    chk_retry_high: assert property (
        conv_done && busy && mux_ctia_closed && sense_current == CUR_1MA1
        && conv_result < low_z_threshold
        |-> ##[1:4] (conv_start && sense_current == CUR_5MA5))
        else $error("no 5.5 mA retry");
    chk_manual_start: assert property (
        $rose(manual_measure_trigger) && man_ok |-> ##2
        (conv_start && sense_current == $past(sense_current_select, 2)))
        else $error("manual start wrong");
    chk_result_taken: assert property (
        result_valid |-> $past(conv_done, 2) &&
        result == $past(conv_result, 2))
        else $error("result not converter reading");
    chk_removal_opens: assert property (
        remove_event |-> !jack_present_low ##[0:2]
        (!mux_ctia_closed && !sense_current_on))
        else $error("removal left switches");
    chk_irq_pin: assert property (
        !int_n_out && int_n_oe == $past(irq_pending))
        else $error("interrupt pin misdriven");

    cover property (auto_go);
    cover property (conv_start && sense_current == CUR_5MA5);
    cover property (result_valid && !mux_ctia_closed);
endmodule
bind hzs_sequencer hzs_sequencer_chk i_chk (.clock, .reset,
    .startup_done, .manual_measure_trigger, .measure_start_select,
    .open_check_enable, .low_z_threshold, .irq_pending, .conv_done,
    .conv_result, .conv_start, .sense_current_on, .sense_current,
    .sense_current_select, .mux_ctia_closed, .device_ready,
    .jack_present_low, .insert_event, .remove_event, .busy,
    .result_valid, .result, .int_n_out, .int_n_oe);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import hzs_pkg::*;
    localparam int unsigned SH = 20;
    localparam int unsigned LG = 50;
    logic clock = 0, reset = 1, startup_done = 0, jack_sense_input = 1;
    logic insert_debounce_select = 0, open_check_enable = 0;
    logic manual_measure_trigger = 0, sense_current_select_wr = 0;
    logic irq_pending = 0;
    logic [1:0] measure_start_select = 0, sense_current_select_wdata = 0;
    logic [7:0] high_z_threshold = 0, low_z_threshold = 0;
    logic [3:0] delay = 0;
    logic [23:0] levels = 0;
    logic conv_start, conv_done, sense_current_on, mux_ctia_closed;
    logic device_ready, jack_present_low, insert_event, remove_event;
    logic busy, result_valid, int_n_out, int_n_oe;
    logic [7:0] conv_result, result;
    logic [1:0] sense_current, sense_current_select;
    int err_count = 0, compares = 0, cyc = 0;
    logic [7:0] r_keep;

    hzs_sequencer #(.DEB_SHORT_CYC(SH), .DEB_LONG_CYC(LG))
        i_hzs_sequencer (.clock, .reset, .startup_done,
        .jack_sense_input, .insert_debounce_select, .open_check_enable,
        .measure_start_select, .manual_measure_trigger,
        .high_z_threshold, .low_z_threshold, .sense_current_select_wr,
        .sense_current_select_wdata, .irq_pending, .conv_start,
        .conv_done, .conv_result, .sense_current_on, .sense_current,
        .mux_ctia_closed, .device_ready, .jack_present_low,
        .insert_event, .remove_event, .busy, .result_valid, .result,
        .sense_current_select, .int_n_out, .int_n_oe);
    hzs_conv_model i_hzs_conv_model (.clock, .reset, .conv_start,
        .sense_current, .conv_done, .conv_result, .levels, .delay);

    initial forever #25 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task tick(int n = 1);
        repeat (n) @(negedge clock);
    endtask
    task chk(logic [7:0] got, logic [7:0] exp, string m);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    function automatic logic [1:0] exp_cur(logic o, logic [23:0] lv,
        logic [7:0] h, logic [7:0] l);
        if (o && lv[7:0] >= h)
            return CUR_100UA;
        if (lv[15:8] >= l)
            return CUR_1MA1;
        return CUR_5MA5;
    endfunction
    task insert();
        int k;
        int n;
        n = insert_debounce_select ? LG : SH;
        k = 0;
        jack_sense_input = 0;
        while (insert_event !== 1'b1 && k < 200)
        begin
            tick();
            k++;
        end
        chk(8'(k >= n && k <= n + 5), 1, "insert time");
        chk(jack_present_low, 1, "present");
    endtask
    task remove();
        int k;
        k = 0;
        jack_sense_input = 1;
        while (remove_event !== 1'b1 && k < 20)
        begin
            tick();
            k++;
        end
        chk(remove_event, 1, "removal");
        tick();
    endtask
    task wait_rv();
        int k;
        k = 0;
        while (result_valid !== 1'b1 && k < 300)
        begin
            tick();
            k++;
        end
        chk(result_valid, 1, "no result");
    endtask
    task no_result(string m);
        logic [7:0] r0;
        logic [7:0] h;
        r0 = result;
        h = 0;
        repeat (30)
        begin
            tick();
            h += 8'(result_valid !== 1'b0);
        end
        chk(h, 0, m);
        chk(result, r0, m);
        $display("test %s done", m);
    endtask
    task auto_run(logic o, logic [23:0] lv, logic [7:0] h, logic [7:0] l);
        logic [1:0] c;
        c = exp_cur(o, lv, h, l);
        measure_start_select = $urandom_range(0, 1) ? 2'h3 : 2'h0;
        open_check_enable = o;
        levels = lv;
        high_z_threshold = h;
        low_z_threshold = l;
        delay = 4'($urandom_range(0, 15));
        insert();
        wait_rv();
        chk(busy, 0, "idle after run");
        chk(result, lv[c*8 +: 8], "auto result");
        chk(sense_current_select, c, "select load");
        remove();
        $display("test auto done");
    endtask
    task man_run(logic [1:0] c, logic [7:0] r);
        measure_start_select = c[0] ? 2'h1 : 2'h2;
        levels[c*8 +: 8] = r;
        sense_current_select_wdata = c;
        sense_current_select_wr = 1;
        tick();
        sense_current_select_wr = 0;
        tick();
        manual_measure_trigger = 1;
        wait_rv();
        chk(result, r, "manual result");
        chk(sense_current_select, c, "select kept");
        manual_measure_trigger = 0;
        tick();
        $display("test manual done");
    endtask
    task complete_run();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(27));
        tick(3);
        reset = 0;
        insert();
        no_result("before ready");
        remove();
        startup_done = 1;
        tick(2);
        chk(device_ready, 1, "ready");
        irq_pending = 1;
        tick();
        chk(int_n_oe, 1, "irq on");
        chk(int_n_out, 0, "irq low");
        irq_pending = 0;
        tick();
        chk(int_n_oe, 0, "irq off");
        insert_debounce_select = 1;
        auto_run(1, 24'h30_2040, 8'h80, 8'h30);
        insert_debounce_select = 0;
        auto_run(0, 24'h11_9922, 8'hff, 8'h99);
        auto_run(1, 24'h11_22a0, 8'ha0, 8'h50);
        repeat (12)
            auto_run(1'($urandom), 24'($urandom), 8'($urandom),
                8'($urandom));
        delay = 4'hf;
        r_keep = result;
        insert();
        tick(2);
        chk(busy, 1, "busy run");
        remove();
        no_result("abort");
        chk(result, r_keep, "abort kept");
        measure_start_select = 2'h1;
        insert();
        no_result("manual idle");
        for (int c = 0; c < 3; c++)
            man_run(2'(c), 8'($urandom));
        remove();
        manual_measure_trigger = 1;
        no_result("absent trigger");
        manual_measure_trigger = 0;
        complete_run();
    end
endmodule
`default_nettype wire
